// ### logic/restart_pulse_check.sv
// Purpose: Validates a low-high-low restart pulse by its high width.
// Assumes: Input synchronous to the clock.
// Notes:   One-cycle valid pulse on the falling edge of a good pulse.
`timescale 1ns/10ps
`default_nettype none
module restart_pulse_check #(
  parameter int unsigned MIN_CYC = safety_pkg::RESTART_MIN_CYC,
  parameter int unsigned MAX_CYC = safety_pkg::RESTART_MAX_CYC
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic ce_i,
  input  wire logic level_i,
  output var  logic valid_o
);
  import safety_pkg::*;

  logic             level_ff;
  logic [CNT_W-1:0] width_ff;

  // Edge and window decode
  wire logic rise_w   = level_i & ~level_ff;
  wire logic fall_w   = ~level_i & level_ff;
  wire logic sat_w    = (width_ff == CNT_W'(MAX_CYC + 1));
  wire logic in_win_w = (width_ff >= CNT_W'(MIN_CYC)) &&
                        (width_ff <= CNT_W'(MAX_CYC));

  // Width counter saturates just past the longest pulse
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      level_ff <= 1'b1; // A level already high after reset is no rise
      width_ff <= '0;
      valid_o  <= 1'b0;
    end else if (ce_i) begin
      level_ff <= level_i;
      valid_o  <= fall_w & in_win_w;
      if (rise_w)
        width_ff <= CNT_W'(1);
      else if (level_i && !sat_w)
        width_ff <= width_ff + CNT_W'(1);
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  AST_RESTART_SHORT: assert property (
    (ce_i && fall_w && width_ff < CNT_W'(MIN_CYC)) |=> !valid_o)
    else $error("short restart pulse accepted");
  AST_RESTART_LONG: assert property (
    (ce_i && fall_w && sat_w) |=> !valid_o)
    else $error("overlong restart pulse accepted");

endmodule // restart_pulse_check
`default_nettype wire

// ### logic/safety_output_interlock.sv
// Purpose: Drives two redundant safety outputs from the guard condition.
// Assumes: Guard inputs come from the distance evaluator, in clock domain.
// Notes:   Registers over APB, one wait state on every access.
//
// Overview of operation
// - Guard open at or past release distance drops both outputs, every mode.
// - Manual mode holds outputs low after closure until a restart pulse.
// - Restart valid only if high between 30 ms and 5 s.
// - Manual feedback monitoring armed after start-up, chain set, one restart.
// - Automatic with feedback raises outputs only if feedback is correct.
// - Feedback must open within 500 ms of outputs on, else fault.
// - Automatic without feedback ignores feedback, outputs follow closure.
// - Chain a on output a, chain b on status enters programming.
// - Chain inputs carry an upstream sensor's safety outputs.
// - Status output shows state live; no safety decision reads it.
// - Test pulses pull high outputs low for 80 to 120 us.
// - Test pulses repeat each second, channels shifted by 500 ms.
// - Output readback checked against test pulses to find faults.
`timescale 1ns/10ps
`default_nettype none
module safety_output_interlock #(
  parameter int unsigned RESTART_MIN = safety_pkg::RESTART_MIN_CYC,
  parameter int unsigned RESTART_MAX = safety_pkg::RESTART_MAX_CYC,
  parameter int unsigned FBK_MAX     = safety_pkg::FBK_MAX_CYC,
  parameter int unsigned PULSE_W     = safety_pkg::PULSE_CYC,
  parameter int unsigned PERIOD      = safety_pkg::PERIOD_CYC,
  parameter int unsigned SHIFT       = safety_pkg::SHIFT_CYC
) (
  input  wire logic        SYS_CLK_I,
  input  wire logic        RST_I,
  input  wire logic        CE_I,
  input  wire logic        PSEL_I,
  input  wire logic        PENABLE_I,
  input  wire logic        PWRITE_I,
  input  wire logic [7:0]  PADDR_I,
  input  wire logic [31:0] PWDATA_I,
  output var  logic [31:0] PRDATA_O,
  output var  logic        PREADY_O,
  output var  logic        PSLVERR_O,
  input  wire logic        GUARD_CLOSED_I,
  input  wire logic        GUARD_OPEN_I,
  input  wire logic        CHAIN_INPUT_A_I,
  input  wire logic        CHAIN_INPUT_B_I,
  input  wire logic        FEEDBACK_RESTART_I,
  input  wire logic        SENSE_A_I,
  input  wire logic        SENSE_B_I,
  output var  logic        SAFETY_OUT_A_O,
  output var  logic        SAFETY_OUT_B_O,
  output var  logic        STATUS_O,
  output var  logic        IRQ_O
);
  import safety_pkg::*;

  ctrl_type         ctrl_ff;
  logic [IRQ_W-1:0] irq_stat_ff;
  logic [IRQ_W-1:0] irq_mask_ff;
  state_type        state_ff;
  state_type        nxt_state;
  flags_type        flags_ff;
  logic [3:0]       probe_cnt_ff;
  logic             hi_b_ff;
  logic             hi_f_ff;
  logic             hi_a_ff;
  logic [CNT_W-1:0] fbk_cnt_ff;
  logic             open_ff;
  logic             blink_ff;
  logic             restart_valid;
  logic [1:0]       pulse;
  logic [1:0]       last;

  // APB decode
  wire logic access_w = PSEL_I & PENABLE_I;
  wire logic done_w   = access_w & PREADY_O;
  wire logic wr_w     = done_w & PWRITE_I;
  wire logic sel_ctrl = (PADDR_I == CTRL_OFS);
  wire logic sel_st   = (PADDR_I == STATE_OFS);
  wire logic sel_is   = (PADDR_I == IRQ_STAT_OFS);
  wire logic sel_im   = (PADDR_I == IRQ_MASK_OFS);
  wire logic mapped_w = sel_ctrl | sel_st | sel_is | sel_im;

  // Read word selection
  wire logic [31:0] rd_word =
    sel_ctrl ? {28'h0, ctrl_ff} :
    sel_st   ? {25'h0, flags_ff, state_ff} :
    sel_is   ? {28'h0, irq_stat_ff} :
    sel_im   ? {28'h0, irq_mask_ff} : 32'h0;

  // Mode and gating decode
  wire logic manual_w = ctrl_ff.mode[1];
  wire logic auto_fbk = (ctrl_ff.mode == MODE_AUTO_FBK);
  wire logic man_fbk  = (ctrl_ff.mode == MODE_MAN_FBK);
  // Upstream sensor outputs gate closure when chained
  wire logic chain_ok = ~ctrl_ff.chain_en |
                        (CHAIN_INPUT_A_I & CHAIN_INPUT_B_I);
  // Closure only on a clear operate indication; between, hold
  wire logic closed_w = GUARD_CLOSED_I & ~GUARD_OPEN_I;
  // Contacts must read closed before outputs rise
  wire logic fbk_ready = ~auto_fbk | FEEDBACK_RESTART_I;
  wire logic close_ok  = closed_w & chain_ok & fbk_ready;
  wire logic probe_done = (probe_cnt_ff == 4'(PROBE_CYC - 1));
  // Feedback timing watched in auto feedback, or manual once armed
  wire logic fbk_mon  = auto_fbk | (man_fbk & flags_ff.fbk_ok);
  wire logic fbk_fault = (state_ff == ST_GUARD) & fbk_mon &
                         FEEDBACK_RESTART_I &
                         (fbk_cnt_ff == CNT_W'(FBK_MAX));
  // Readback must be low at the end of own pulse, high at the other's
  wire logic out_fault = (state_ff == ST_GUARD) &
    ((last[0] & (SENSE_A_I | ~SENSE_B_I)) |
     (last[1] & (SENSE_B_I | ~SENSE_A_I)));
  wire logic fault_w = fbk_fault | out_fault;
  // Loopback probes seen over the two start-up phases
  wire logic teach_hit = hi_b_ff & ~CHAIN_INPUT_B_I &
                         ~hi_a_ff & ~CHAIN_INPUT_A_I;
  wire logic first_hit = hi_f_ff & ~FEEDBACK_RESTART_I &
                         CHAIN_INPUT_A_I & CHAIN_INPUT_B_I;
  wire logic on_w = (nxt_state == ST_GUARD);

  // Events for the sticky status register
  wire logic [IRQ_W-1:0] irq_evt = {
    out_fault,
    fbk_fault,
    restart_valid,
    GUARD_OPEN_I & ~open_ff
  };
  wire logic [IRQ_W-1:0] irq_clr = (wr_w & sel_is) ?
                                   PWDATA_I[IRQ_W-1:0] : '0;

  // Restart pulse qualifier on the shared feedback and restart input
  restart_pulse_check #(
    .MIN_CYC (RESTART_MIN),
    .MAX_CYC (RESTART_MAX)
  ) u_restart (
    .clk_i   (SYS_CLK_I),
    .rst_i   (RST_I),
    .ce_i    (CE_I),
    .level_i (FEEDBACK_RESTART_I),
    .valid_o (restart_valid)
  );

  // Test pulse timebase
  test_pulse_gen #(
    .PERIOD (PERIOD),
    .WIDTH  (PULSE_W),
    .SHIFT  (SHIFT)
  ) u_pulse (
    .clk_i   (SYS_CLK_I),
    .rst_i   (RST_I),
    .ce_i    (CE_I),
    .pulse_o (pulse),
    .last_o  (last)
  );

  // Next state of the output interlock
  always_comb begin
    nxt_state = state_ff;
    if (state_ff == ST_FAIL)
      nxt_state = ST_FAIL;
    else if (!ctrl_ff.run && !(state_ff == ST_GUARD && fault_w))
      nxt_state = ST_IDLE; // A fault seen as run drops still latches
    else begin
      case (state_ff)
        ST_IDLE:
          nxt_state = ST_PROBE_HI;
        ST_PROBE_HI: begin
          if (probe_done)
            nxt_state = ST_PROBE_LO;
        end
        ST_PROBE_LO: begin
          if (probe_done)
            nxt_state = teach_hit ? ST_PROGRAM : ST_BREAK;
        end
        ST_BREAK: begin
          if (close_ok)
            nxt_state = manual_w ? ST_RESTART : ST_GUARD;
        end
        ST_RESTART: begin
          if (GUARD_OPEN_I || !chain_ok)
            nxt_state = ST_BREAK;
          else if (restart_valid)
            nxt_state = ST_GUARD;
        end
        ST_GUARD: begin
          if (fault_w)
            nxt_state = ST_FAIL;
          else if (GUARD_OPEN_I || !chain_ok)
            nxt_state = ST_BREAK;
        end
        ST_PROGRAM:
          nxt_state = ST_PROGRAM;
        default:
          nxt_state = ST_IDLE;
      endcase
    end
  end

  // State, probe samples and start-up flags
  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      state_ff     <= ST_IDLE;
      probe_cnt_ff <= 4'h0;
      hi_a_ff      <= 1'b0;
      hi_b_ff      <= 1'b0;
      hi_f_ff      <= 1'b0;
      flags_ff     <= '0;
    end else if (CE_I) begin
      state_ff     <= nxt_state;
      probe_cnt_ff <= (nxt_state != state_ff) ? 4'h0 : probe_cnt_ff + 4'h1;
      if (state_ff == ST_PROBE_HI && probe_done) begin
        hi_a_ff <= CHAIN_INPUT_A_I;
        hi_b_ff <= CHAIN_INPUT_B_I;
        hi_f_ff <= FEEDBACK_RESTART_I;
      end
      if (state_ff == ST_PROBE_LO && probe_done) begin
        flags_ff.teach       <= teach_hit;
        flags_ff.chain_first <= first_hit;
      end
      if (restart_valid)
        flags_ff.restart_seen <= 1'b1;
      if (man_fbk && flags_ff.restart_seen && chain_ok &&
          state_ff >= ST_BREAK)
        flags_ff.fbk_ok <= 1'b1;
    end
  end

  // Feedback delay counter, open edge tracker and fail blink
  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      fbk_cnt_ff <= '0;
      open_ff    <= 1'b1; // Guard already open at reset is no event
      blink_ff   <= 1'b0;
    end else if (CE_I) begin
      open_ff <= GUARD_OPEN_I;
      if (state_ff != ST_GUARD || !FEEDBACK_RESTART_I)
        fbk_cnt_ff <= '0;
      else if (fbk_cnt_ff != CNT_W'(FBK_MAX))
        fbk_cnt_ff <= fbk_cnt_ff + CNT_W'(1);
      if (last[0])
        blink_ff <= ~blink_ff;
    end
  end

  // Safety outputs and status, test pulses cut each high output
  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      SAFETY_OUT_A_O <= 1'b0;
      SAFETY_OUT_B_O <= 1'b0;
      STATUS_O       <= 1'b0;
    end else if (CE_I) begin
      SAFETY_OUT_A_O <= on_w & ~pulse[0];
      SAFETY_OUT_B_O <= on_w & ~pulse[1];
      STATUS_O       <= on_w | (nxt_state == ST_PROBE_HI) |
                        ((nxt_state == ST_FAIL) & blink_ff);
    end
  end

  // APB slave: one wait state, then answer
  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      PREADY_O  <= 1'b0;
      PRDATA_O  <= 32'h0;
      PSLVERR_O <= 1'b0;
    end else if (CE_I) begin
      PREADY_O  <= access_w & ~PREADY_O;
      PRDATA_O  <= (access_w & ~PREADY_O & ~PWRITE_I) ? rd_word : 32'h0;
      PSLVERR_O <= access_w & ~PREADY_O & ~mapped_w;
    end
  end

  // Control and mask registers; unmapped writes are dropped
  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      ctrl_ff     <= ctrl_type'(CTRL_RST);
      irq_mask_ff <= IRQ_MASK_RST;
    end else if (CE_I) begin
      if (wr_w && sel_ctrl)
        ctrl_ff <= ctrl_type'(PWDATA_I[3:0]);
      if (wr_w && sel_im)
        irq_mask_ff <= PWDATA_I[IRQ_W-1:0];
    end
  end

  // Sticky events, write one to clear, a new event wins
  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      irq_stat_ff <= '0;
      IRQ_O       <= 1'b0;
    end else if (CE_I) begin
      irq_stat_ff <= (irq_stat_ff & ~irq_clr) | irq_evt;
      IRQ_O       <= |(((irq_stat_ff & ~irq_clr) | irq_evt) & irq_mask_ff);
    end
  end

  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (RST_I);

  sequence s_wait_restart;
    (state_ff == ST_RESTART) && !restart_valid;
  endsequence

  sequence s_fbk_late;
    CE_I && (state_ff == ST_GUARD) && fbk_mon && FEEDBACK_RESTART_I &&
    (fbk_cnt_ff == CNT_W'(FBK_MAX));
  endsequence

  AST_OPEN_OFF: assert property (
    (CE_I && GUARD_OPEN_I) |=> !SAFETY_OUT_A_O && !SAFETY_OUT_B_O)
    else $error("outputs stayed high with guard open");
  AST_MANUAL_HOLD: assert property (
    s_wait_restart |=> !SAFETY_OUT_A_O && !SAFETY_OUT_B_O)
    else $error("manual mode raised outputs without restart");
  AST_FBK_GATE: assert property (
    (CE_I && state_ff == ST_BREAK && auto_fbk && !FEEDBACK_RESTART_I)
    |=> state_ff != ST_GUARD)
    else $error("outputs raised with feedback open");
  AST_FBK_TIMEOUT: assert property (
    s_fbk_late |=> (state_ff == ST_FAIL) ##1 !SAFETY_OUT_A_O)
    else $error("late feedback not faulted");
  AST_NOFBK_DIRECT: assert property (
    (CE_I && ctrl_ff.run && state_ff == ST_BREAK &&
     ctrl_ff.mode == MODE_AUTO_NOFBK && closed_w && chain_ok)
    |=> state_ff == ST_GUARD)
    else $error("automatic mode did not raise outputs on closure");
  AST_HYSTERESIS: assert property (
    (CE_I && state_ff == ST_BREAK && !GUARD_CLOSED_I)
    |=> state_ff != ST_GUARD && state_ff != ST_RESTART)
    else $error("outputs moved between operate and release");
  AST_SELF_CHECK: assert property (
    (CE_I && out_fault) |=> state_ff == ST_FAIL)
    else $error("readback fault not caught");
  AST_FAIL_LATCH: assert property (
    (state_ff == ST_FAIL) |=> (state_ff == ST_FAIL) && !SAFETY_OUT_B_O)
    else $error("fail state released before reset");
  AST_PULSE_CUT: assert property (
    (CE_I && pulse[0]) |=> !SAFETY_OUT_A_O)
    else $error("output a high during its test pulse");

endmodule // safety_output_interlock
`default_nettype wire

// ### logic/test_pulse_gen.sv
// Purpose: Timebase for the periodic low test pulses of both outputs.
// Assumes: Free-running while the clock enable is high.
// Notes:   Channel b pulses one shift after channel a.
`timescale 1ns/10ps
`default_nettype none
module test_pulse_gen #(
  parameter int unsigned PERIOD = safety_pkg::PERIOD_CYC,
  parameter int unsigned WIDTH  = safety_pkg::PULSE_CYC,
  parameter int unsigned SHIFT  = safety_pkg::SHIFT_CYC
) (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       ce_i,
  output var  logic [1:0] pulse_o,
  output wire logic [1:0] last_o
);
  import safety_pkg::*;

  logic [CNT_W-1:0] cnt_ff;

  // Period counter
  always_ff @(posedge clk_i) begin
    if (rst_i)
      cnt_ff <= '0;
    else if (ce_i)
      cnt_ff <= (cnt_ff == CNT_W'(PERIOD - 1)) ? '0 : cnt_ff + CNT_W'(1);
  end

  // One pulse window per channel
  for (genvar i = 0; i < 2; i++) begin : g_chan
    localparam logic [CNT_W-1:0] START = CNT_W'(i * SHIFT);
    localparam logic [CNT_W-1:0] STOP  = CNT_W'(i * SHIFT + WIDTH);
    always_ff @(posedge clk_i) begin
      if (rst_i)
        pulse_o[i] <= 1'b0;
      else if (ce_i)
        pulse_o[i] <= (cnt_ff >= START) && (cnt_ff < STOP);
    end
    assign last_o[i] = pulse_o[i] && (cnt_ff == STOP);
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  AST_PULSE_SHIFT: assert property (
    $rose(pulse_o[1]) |-> (cnt_ff == CNT_W'(SHIFT + 1)))
    else $error("channel b pulse not shifted from channel a");
  AST_PULSE_LEN: assert property (
    pulse_o[0] |-> (cnt_ff >= CNT_W'(1)) && (cnt_ff <= CNT_W'(WIDTH)))
    else $error("test pulse outside its width");

endmodule // test_pulse_gen
`default_nettype wire

// ### pkg/safety_pkg.sv
// Purpose: Shared constants and types for the safety output interlock.
// Assumes: 50 MHz system clock, 32-bit APB register access.
// Notes:   Long cycle counts are defaults for top-level parameters.
package safety_pkg;

  // Clock and printed times
  localparam int unsigned CLK_HZ         = 50_000_000;
  localparam int unsigned RESTART_MIN_MS = 30;
  localparam int unsigned RESTART_MAX_MS = 5000;
  localparam int unsigned FBK_MAX_MS     = 500;
  localparam int unsigned PULSE_US       = 100;
  localparam int unsigned PERIOD_MS      = 1000;
  localparam int unsigned SHIFT_MS       = 500;

  // Derived cycle counts; clock divided first, all truncated, exact at 50 MHz
  localparam int unsigned RESTART_MIN_CYC = (CLK_HZ / 1000) * RESTART_MIN_MS;
  localparam int unsigned RESTART_MAX_CYC = (CLK_HZ / 1000) * RESTART_MAX_MS;
  localparam int unsigned FBK_MAX_CYC     = (CLK_HZ / 1000) * FBK_MAX_MS;
  localparam int unsigned PULSE_CYC       = (CLK_HZ / 1000000) * PULSE_US;
  localparam int unsigned PERIOD_CYC      = (CLK_HZ / 1000) * PERIOD_MS;
  localparam int unsigned SHIFT_CYC       = (CLK_HZ / 1000) * SHIFT_MS;
  localparam int unsigned PROBE_CYC       = 16;

  // Counter width, covers the 5 s restart limit plus one
  localparam int unsigned CNT_W = 28;

  // Register byte offsets
  localparam logic [7:0] CTRL_OFS     = 8'h00;
  localparam logic [7:0] STATE_OFS    = 8'h04;
  localparam logic [7:0] IRQ_STAT_OFS = 8'h08;
  localparam logic [7:0] IRQ_MASK_OFS = 8'h0c;

  // Interrupt bit positions
  localparam int unsigned IRQ_W       = 4;
  localparam int unsigned IRQ_OPEN    = 0;
  localparam int unsigned IRQ_RESTART = 1;
  localparam int unsigned IRQ_FBK     = 2;
  localparam int unsigned IRQ_OUT     = 3;

  // Operating modes, as held in the control register
  typedef enum logic [1:0] {
    MODE_AUTO_NOFBK  = 2'h0,
    MODE_AUTO_FBK    = 2'h1,
    MODE_MAN_NOFBK   = 2'h2,
    MODE_MAN_FBK     = 2'h3
  } mode_type;

  // Control register: bit0 run, bits2:1 mode, bit3 chain enable
  typedef struct packed {
    logic     chain_en;
    mode_type mode;
    logic     run;
  } ctrl_type;

  localparam logic [3:0]       CTRL_RST     = 4'h0;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 4'h0;

  // Flags shown in the state register above the state code
  typedef struct packed {
    logic restart_seen;
    logic chain_first;
    logic teach;
    logic fbk_ok;
  } flags_type;

  typedef enum logic [2:0] {
    ST_IDLE, ST_PROBE_HI, ST_PROBE_LO, ST_BREAK,
    ST_RESTART, ST_GUARD, ST_PROGRAM, ST_FAIL
  } state_type;

endpackage

// ### sim/contactor_model.sv
// Purpose: Far side: load contactors, restart button, readback.
// Assumes: Contacts open dly_i cycles after the outputs come on.
// Notes:   weld_i keeps contacts open, stuck_i jams readback a.
`timescale 1ns/10ps
`default_nettype none
module contactor_model
  import safety_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       out_a_i,
  input  wire logic       out_b_i,
  input  wire logic       btn_i,
  input  wire logic       weld_i,
  input  wire logic       stuck_i,
  input  wire mode_type   mode_i,
  input  wire logic [7:0] dly_i,
  output wire logic       fb_o,
  output wire logic       sense_a_o,
  output wire logic       sense_b_o
);
  int   on_cnt;
  logic on;
  logic nc;
  // Cycles since the outputs switched on
  assign on = out_a_i | out_b_i;
  always_ff @(posedge clk_i) begin
    on_cnt <= on ? on_cnt + 1 : 0;
  end
  // Closed while off, opens late once on
  assign nc = !weld_i && !(on && on_cnt >= dly_i);
  // Wiring of the shared input per mode
  assign fb_o = (mode_i == MODE_AUTO_NOFBK) ? 1'b1 :
                (mode_i == MODE_AUTO_FBK)   ? nc :
                (mode_i == MODE_MAN_NOFBK)  ? btn_i : nc & btn_i;
  assign sense_a_o = out_a_i | stuck_i;
  assign sense_b_o = out_b_i;
endmodule // contactor_model
`default_nettype wire

// ### sim/tb_safety_output_interlock.sv
// Purpose: Self-checking bench for the safety output interlock.
// Assumes: Shortened counts; contactor model drives feedback.
// Notes:   One restart width and one contact delay come from xorshift.
`timescale 1ns/10ps
`default_nettype none
module tb_safety_output_interlock;
  import safety_pkg::*;
  localparam int RMIN = 20, RMAX = 60, FMAX = 30;
  localparam int PW = 4, PER = 200, SH = 100;
  logic        clk, rst, psel, pen, pwr, closed, opn, btn, weld;
  logic        stuck, err, pready, pslverr, oa, ob, sa, sb, fb;
  logic        status, irq;
  logic [1:0]  chn, wiring;
  logic [7:0]  paddr, dly;
  logic [31:0] pwdata, prdata, rdv, seed;
  mode_type    mode;
  int          miscompares, tests_run, n, m;
  int          wd [5];
  // Chain inputs from an upstream sensor, or looped back
  safety_output_interlock #(.RESTART_MIN(RMIN), .RESTART_MAX(RMAX),
    .FBK_MAX(FMAX), .PULSE_W(PW), .PERIOD(PER), .SHIFT(SH)) uut (
    .SYS_CLK_I(clk), .RST_I(rst), .CE_I(1'b1), .PSEL_I(psel),
    .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr),
    .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
    .PSLVERR_O(pslverr), .GUARD_CLOSED_I(closed),
    .GUARD_OPEN_I(opn), .CHAIN_INPUT_A_I(wiring == 2'h1 ? oa : chn[1]),
    .CHAIN_INPUT_B_I(wiring == 2'h1 ? status : chn[0]),
    .FEEDBACK_RESTART_I(wiring == 2'h2 ? status : fb),
    .SENSE_A_I(sa), .SENSE_B_I(sb), .SAFETY_OUT_A_O(oa),
    .SAFETY_OUT_B_O(ob), .STATUS_O(status), .IRQ_O(irq));
  contactor_model k (.clk_i(clk), .out_a_i(oa), .out_b_i(ob),
    .btn_i(btn), .weld_i(weld), .stuck_i(stuck), .mode_i(mode),
    .dly_i(dly), .fb_o(fb), .sense_a_o(sa), .sense_b_o(sb));
  // 50 MHz clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // Restart width accepted inside the window
  function automatic logic good(input int w);
    return w >= RMIN && w <= RMAX;
  endfunction
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      miscompares++;
      $display("wrong value at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic tick(input int c);
    repeat (c) @(posedge clk);
  endtask
  // One APB transfer, waits for pready under a bound
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int c;
    c = 0;
    psel   <= 1'b1;
    pwr    <= w;
    paddr  <= a;
    pwdata <= d;
    tick(1);
    pen <= 1'b1;
    do begin
      tick(1);
      c++;
    end while (pready !== 1'b1 && c < 20);
    if (c >= 20) miscompares++;
    rdv = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen  <= 1'b0;
    tick(1);
  endtask
  task automatic guard(input logic c, input logic o, input int w);
    closed <= c;
    opn    <= o;
    tick(w);
  endtask
  task automatic press(input int w);
    btn <= 1'b1;
    tick(w);
    btn <= 1'b0;
    tick(4);
  endtask
  // Reset, set mode with run, wait out start-up
  task automatic start(input mode_type md);
    rst  <= 1'b1;
    mode <= md;
    guard(1'b0, 1'b1, 2);
    rst <= 1'b0;
    apb(1'b1, CTRL_OFS, {28'h0, 1'b0, md, 1'b1});
    tick(40);
    apb(1'b0, STATE_OFS, 32'h0);
    chk(rdv[6:0], {1'b0, wiring, 1'b0,
        wiring[0] ? ST_PROGRAM : ST_BREAK});
    chk({oa, ob, status}, 3'h0);
  endtask
  // Counts cycles until output b or a reaches level lv
  task automatic waitlvl(input bit b, input logic lv, output int c);
    c = 0;
    while ((b ? ob : oa) !== lv && c < 2 * PER) begin
      tick(1);
      c++;
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d wrong %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    {rst, psel, pen, pwr, closed, btn, weld, stuck} = 8'h80;
    opn    = 1'b1;
    chn    = 2'h3;
    wiring = 2'h0;
    paddr  = 8'h00;
    pwdata = 32'h0;
    dly    = 8'h05;
    mode   = MODE_AUTO_NOFBK;
    seed   = 32'h000184e4;
    tick(12);
    rst <= 1'b0;
    apb(1'b0, CTRL_OFS, 32'h0);
    chk(rdv, {28'h0, CTRL_RST});
    apb(1'b0, IRQ_MASK_OFS, 32'h0);
    chk(rdv, {28'h0, IRQ_MASK_RST});
    apb(1'b1, IRQ_MASK_OFS, 32'h0000000f);
    apb(1'b0, IRQ_MASK_OFS, 32'h0);
    chk(rdv, 32'h0000000f);
    apb(1'b0, 8'h10, 32'h0);
    chk({err, rdv[7:0]}, 9'h100);
    $display("test regs done");
    start(MODE_AUTO_NOFBK);
    guard(1'b1, 1'b0, 2);
    chk({oa | ob, status}, 2'h3);
    guard(1'b0, 1'b0, 40);
    chk(oa | ob, 1'b1);
    guard(1'b0, 1'b1, 2);
    chk({oa, ob}, 2'h0);
    guard(1'b0, 1'b0, 40);
    chk({oa, ob}, 2'h0);
    $display("test auto done");
    guard(1'b1, 1'b0, 2);
    waitlvl(0, 1'b0, n);
    waitlvl(0, 1'b1, n);
    chk(n, PW);
    waitlvl(1, 1'b0, m);
    chk(n + m, SH);
    waitlvl(1, 1'b1, n);
    chk(n, PW);
    waitlvl(0, 1'b0, m);
    chk(n + m, PER - SH);
    stuck <= 1'b1;
    tick(PER + 8);
    chk({oa, ob}, 2'h0);
    apb(1'b0, IRQ_STAT_OFS, 32'h0);
    chk(rdv[IRQ_OUT], 1'b1);
    stuck <= 1'b0;
    $display("test pulses done");
    start(MODE_MAN_NOFBK);
    guard(1'b1, 1'b0, 10);
    chk(oa | ob, 1'b0);
    wd = '{RMIN - 1, RMAX + 1, RMIN, RMAX, RMIN + 1 + xs() % 39};
    foreach (wd[i]) begin
      press(wd[i]);
      chk(oa | ob, good(wd[i]));
      if (good(wd[i])) begin
        guard(1'b0, 1'b1, 3);
        guard(1'b1, 1'b0, 3);
      end
    end
    $display("test manual done");
    start(MODE_AUTO_FBK);
    weld <= 1'b1;
    dly  <= 8'(1 + xs() % 25);
    guard(1'b1, 1'b0, 10);
    chk(oa | ob, 1'b0);
    weld <= 1'b0;
    tick(3);
    chk(oa | ob, 1'b1);
    tick(60);
    apb(1'b0, STATE_OFS, 32'h0);
    chk(rdv[2:0], ST_GUARD);
    guard(1'b0, 1'b1, 3);
    dly <= 8'h28;
    guard(1'b1, 1'b0, 20);
    chk(oa | ob, 1'b1);
    tick(16);
    chk({oa, ob}, 2'h0);
    guard(1'b0, 1'b1, 3);
    guard(1'b1, 1'b0, 5);
    chk({oa, ob, irq}, 3'h0);
    apb(1'b0, IRQ_STAT_OFS, 32'h0);
    chk({rdv[IRQ_FBK], rdv[IRQ_OPEN], rdv[IRQ_OUT]}, 3'h6);
    apb(1'b1, IRQ_MASK_OFS, 32'h4);
    tick(2);
    chk(irq, 1'b1);
    apb(1'b1, IRQ_STAT_OFS, 32'h4);
    tick(2);
    chk(irq, 1'b0);
    $display("test feedback done");
    start(MODE_MAN_FBK);
    guard(1'b1, 1'b0, 3);
    apb(1'b0, STATE_OFS, 32'h0);
    chk(rdv[3], 1'b0);
    press(RMIN + 5);
    chk(oa | ob, 1'b1);
    apb(1'b0, STATE_OFS, 32'h0);
    chk(rdv[3], 1'b1);
    $display("test manual feedback done");
    wiring <= 2'h1;
    start(MODE_AUTO_NOFBK);
    wiring <= 2'h2;
    start(MODE_AUTO_NOFBK);
    wiring <= 2'h0;
    apb(1'b1, CTRL_OFS, 32'h00000009);
    chn <= 2'h2;
    guard(1'b1, 1'b0, 3);
    chk(oa | ob, 1'b0);
    chn <= 2'h3;
    tick(3);
    chk(oa | ob, 1'b1);
    chn <= 2'h1;
    tick(3);
    chk({oa, ob}, 2'h0);
    $display("test chain done");
    print_verdict();
  end
  // Watchdog, well past the few thousand cycles the tests need
  initial begin
    #400000;
    miscompares++;
    print_verdict();
  end
endmodule // tb_safety_output_interlock
`default_nettype wire
